// [rtl/efs_ep0_core.sv]
`timescale 1ns/100ps
`include "efs_regs.svh"
module efs_ep0_core import efs_pkg::*; (
  input  wire logic       clk,                  // 10 MHz core clock
  input  wire logic       sys_rst,              // sync reset, high
  input  wire logic       tok_valid,            // token strobe
  input  wire efs_tok_s   tok,                  // token with endpoint
  input  wire logic [15:0] ep_iso,              // endpoint is isochronous
  input  wire logic [15:0] ep_ready,            // buffer ready to ack
  input  wire logic       xfer_done,            // data packet completed
  input  wire logic [3:0] xfer_ep,              // {dir_in, num} of it
  input  wire logic       setup_byte_valid,     // setup byte strobe
  input  wire logic [7:0] setup_byte,           // setup byte value
  input  wire logic       in_ack,               // host acked ep0 in pkt
  input  wire logic       fw_stall_set,         // firmware sets stall
  input  wire logic       fw_stall_clr,         // firmware clears stall
  input  wire logic [3:0] fw_ep,                // {dir_in, num} target
  input  wire logic       fw_toggle_rst,        // reset toggle to DATA0
  input  wire logic       fw_nak_release,       // write 1 to hold bit
  input  wire logic       fw_ptr_hi_wr,         // write pointer high
  input  wire logic       fw_ptr_lo_wr,         // write pointer low
  input  wire logic [7:0] fw_ptr_byte,          // pointer write data
  input  wire logic       fw_rwu_set,           // set wakeup enable
  input  wire logic       fw_rwu_clr,           // clear wakeup enable
  input  wire logic [2:0] setup_rd_idx,         // setup ram read index
  input  wire logic [7:0] desc_rd_data,         // descriptor ram data
  output logic            hs_valid,             // answer strobe
  output efs_hs_e         hs_code,              // answer kind
  output logic [15:0]     in_pkt_addr,          // auto packet start
  output logic [6:0]      in_pkt_len,           // auto packet length
  output logic            desc_rd_en,           // descriptor ram read
  output logic [15:0]     desc_rd_addr,         // descriptor ram addr
  output logic            setup_data_avail_irq, // setup stored pulse
  output logic            ep0_in_done_irq,      // ep0 in acked pulse
  output logic [15:0]     ep_stall,             // stall per endpoint
  output logic [15:0]     data_pid_odd,         // 1 = next is DATA1
  output logic [7:0]      ep0_control_status,   // ep0 status byte
  output logic [7:0]      setup_rd_data,        // setup ram read data
  output logic            remote_wakeup_enable  // host wakeup permit
);
  // ep0 shares one stall bit between directions
  function automatic logic [3:0] stall_idx(input logic [3:0] e);
    stall_idx = (e[2:0] == 3'h0) ? `EFS_EP0_IDX : e;
  endfunction : stall_idx

  efs_state_e  state_q;
  logic [7:0]  setup_packet_ram [8];
  logic [2:0]  sb_cnt_q;
  logic [15:0] setup_data_pointer;
  logic [7:0]  setup_data_pointer_high;
  logic [15:0] remain_q;
  logic [15:0] stall_q;
  logic [15:0] tog_q;
  logic        handshake_nak_hold;
  logic [3:0]  tok_ep;
  logic [3:0]  tok_si;
  logic [3:0]  fw_si;
  logic        ep0_setup;
  logic        ep0_tok;
  logic [15:0] wlen;
  logic [15:0] dlen;
  logic [15:0] cur_len;

  // token decode
  assign tok_ep    = {tok.dir_in, tok.num};
  assign tok_si    = stall_idx(tok_ep);
  assign fw_si     = stall_idx(fw_ep);
  assign ep0_tok   = tok_valid && (tok.num == 3'h0);
  assign ep0_setup = ep0_tok && (tok.pid == PID_SETUP);
  assign wlen = {setup_packet_ram[`EFS_WLEN_HI],
                 setup_packet_ram[`EFS_WLEN_LO]};
  assign dlen = {8'h00, desc_rd_data};
  // cap each packet at the ep0 buffer size
  assign cur_len = (remain_q > `EFS_PKT_MAX) ? `EFS_PKT_MAX : remain_q;

  // setup bytes land in ram; irq only after the last one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sb_cnt_q             <= 3'h0;
      setup_data_avail_irq <= 1'b0;
    end else begin
      setup_data_avail_irq <= setup_byte_valid &&
                              (sb_cnt_q == `EFS_SETUP_LAST);
      if (ep0_setup) begin
        sb_cnt_q <= 3'h0;
      end else if (setup_byte_valid) begin
        setup_packet_ram[sb_cnt_q] <= setup_byte;
        sb_cnt_q <= sb_cnt_q + 3'h1;
      end
    end
  end

  // firmware read port of the setup ram
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      setup_rd_data <= 8'h00;
    end else begin
      setup_rd_data <= setup_packet_ram[setup_rd_idx];
    end
  end

  // stall bits; a firmware set wins over any clear
  for (genvar i = 0; i < 16; i++) begin : g_stall
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        stall_q[i] <= 1'b0;
      end else if (fw_stall_set && fw_si == 4'(i)) begin
        stall_q[i] <= 1'b1;
      end else if (fw_stall_clr && fw_si == 4'(i)) begin
        stall_q[i] <= 1'b0;
      end else if (i == 0 && ep0_setup) begin
        stall_q[i] <= 1'b0;
      end
    end
  end
  assign ep_stall = stall_q;

  // data toggles flip per good packet; setup forces DATA1
  for (genvar i = 0; i < 16; i++) begin : g_tog
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        tog_q[i] <= 1'b0;
      end else if (ep0_setup && (i == 0 || i == 8)) begin
        tog_q[i] <= 1'b1;
      end else if (fw_toggle_rst && fw_ep == 4'(i)) begin
        tog_q[i] <= 1'b0;
      end else if (xfer_done && xfer_ep == 4'(i)) begin
        tog_q[i] <= ~tog_q[i];
      end
    end
  end
  assign data_pid_odd = tog_q;

  // hold bit: setup sets it, firmware writes 1 to release
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      handshake_nak_hold <= 1'b0;
    end else if (ep0_setup) begin
      handshake_nak_hold <= 1'b1;
    end else if (fw_nak_release) begin
      handshake_nak_hold <= 1'b0;
    end
  end

  // wakeup enable belongs to firmware; set wins over clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      remote_wakeup_enable <= 1'b0;
    end else if (fw_rwu_set) begin
      remote_wakeup_enable <= 1'b1;
    end else if (fw_rwu_clr) begin
      remote_wakeup_enable <= 1'b0;
    end
  end

  // ep0 status byte mirrors the control bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ep0_control_status <= `EFS_CS_RST;
    end else begin
      ep0_control_status <= `EFS_CS_RST;
      ep0_control_status[`EFS_STALL_BIT] <= stall_q[0];
      ep0_control_status[`EFS_HANDSHAKE_NAK_HOLD_BIT] <= handshake_nak_hold;
      ep0_control_status[`EFS_AUTO_BIT]  <= (state_q != ST_IDLE);
    end
  end

  // token answers; iso endpoints get none at all
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hs_valid    <= 1'b0;
      hs_code     <= HS_NAK;
      in_pkt_addr <= `EFS_PTR_RST;
      in_pkt_len  <= 7'h00;
    end else begin
      hs_valid <= tok_valid && !ep_iso[tok_ep];
      if (tok.pid == PID_SETUP) begin
        hs_code <= HS_ACK;
      end else if (stall_q[tok_si]) begin
        hs_code <= HS_STALL;
      end else if (tok.num == 3'h0 && state_q == ST_DATA &&
                   tok.pid == PID_IN) begin
        hs_code     <= HS_DATA;
        in_pkt_addr <= setup_data_pointer;
        in_pkt_len  <= cur_len[6:0];
      end else if (tok.num == 3'h0 && state_q == ST_STAT &&
                   tok.pid == PID_OUT) begin
        hs_code <= HS_ACK;
      end else if (tok.num == 3'h0 &&
                   (state_q != ST_IDLE || handshake_nak_hold)) begin
        hs_code <= HS_NAK;
      end else begin
        hs_code <= ep_ready[tok_ep] ? HS_ACK : HS_NAK;
      end
    end
  end

  // pointer high byte is only stored; low byte starts a run
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      setup_data_pointer_high <= 8'h00;
    end else if (fw_ptr_hi_wr) begin
      setup_data_pointer_high <= fw_ptr_byte;
    end
  end

  // descriptor sequencer; unacked packets resend from same ptr
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q            <= ST_IDLE;
      setup_data_pointer <= `EFS_PTR_RST;
      remain_q           <= 16'h0000;
      desc_rd_en         <= 1'b0;
      desc_rd_addr       <= `EFS_PTR_RST;
    end else begin
      desc_rd_en <= 1'b0;
      if (ep0_setup) begin
        state_q <= ST_IDLE;
      end else if (fw_ptr_lo_wr) begin
        setup_data_pointer <= {setup_data_pointer_high, fw_ptr_byte};
        desc_rd_addr       <= {setup_data_pointer_high, fw_ptr_byte};
        desc_rd_en         <= 1'b1;
        state_q            <= ST_LEN;
      end else begin
        case (state_q)
          ST_LEN: begin
            state_q <= ST_FETCH;
          end
          ST_FETCH: begin
            remain_q <= (wlen < dlen) ? wlen : dlen;
            state_q  <= ST_DATA;
          end
          ST_DATA: begin
            if (in_ack) begin
              setup_data_pointer <= setup_data_pointer + cur_len;
              remain_q           <= remain_q - cur_len;
              if (remain_q == cur_len && cur_len != `EFS_PKT_MAX) begin
                state_q <= ST_STAT;
              end
            end
          end
          ST_STAT: begin
            if (ep0_tok && tok.pid == PID_OUT) begin
              state_q <= ST_IDLE;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ep0 in irq keeps firing during the automatic stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ep0_in_done_irq <= 1'b0;
    end else begin
      ep0_in_done_irq <= in_ack;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_ptr_start;
    fw_ptr_lo_wr && !ep0_setup;
  endsequence
  sequence s_len_read;
    desc_rd_en ##2 state_q == ST_DATA;
  endsequence

  a_stall_answer: assert property (
    tok_valid && tok.pid != PID_SETUP && stall_q[tok_si] &&
    !ep_iso[tok_ep] |=> hs_valid && hs_code == HS_STALL)
    else $error("stalled endpoint not answered with stall");
  a_iso_silent: assert property (
    tok_valid && ep_iso[tok_ep] |=> !hs_valid)
    else $error("isochronous endpoint handshaked");
  a_stall_set: assert property (
    fw_stall_set |=> ep_stall[$past(fw_si)])
    else $error("firmware stall set lost");
  // status byte trails the stall bit by one cycle
  a_ep0_autoclr: assert property (
    ep0_setup && !fw_stall_set |=>
    !ep_stall[0] ##1 !ep0_control_status[`EFS_STALL_BIT])
    else $error("ep0 stall not cleared by setup");
  a_setup_irq: assert property (
    setup_byte_valid && !ep0_setup && sb_cnt_q == `EFS_SETUP_LAST
    |=> setup_data_avail_irq)
    else $error("setup irq missing after eighth byte");
  a_auto_start: assert property (
    s_ptr_start |=> s_len_read and
    desc_rd_addr == {setup_data_pointer_high, $past(fw_ptr_byte)})
    else $error("pointer low write did not start transfer");
  a_pkt_max: assert property (
    hs_valid && hs_code == HS_DATA |-> in_pkt_len <= 7'h40)
    else $error("auto packet longer than 64");
  a_min_len: assert property (
    state_q == ST_FETCH && !ep0_setup && !fw_ptr_lo_wr |=>
    remain_q == (($past(wlen) < $past(dlen)) ? $past(wlen) : $past(dlen)))
    else $error("auto length not the smaller value");
  a_in_irq: assert property (
    in_ack |=> ep0_in_done_irq)
    else $error("ep0 in irq suppressed");
  a_toggle_rst: assert property (
    fw_toggle_rst && !ep0_setup |=> !data_pid_odd[$past(fw_ep)])
    else $error("toggle reset did not select DATA0");
endmodule : efs_ep0_core

// [rtl/efs_regs.svh]
`ifndef EFS_REGS_SVH
`define EFS_REGS_SVH
// largest ep0 data packet in bytes
`define EFS_PKT_MAX      16'h0040
// last setup byte index and requested-length byte positions
`define EFS_SETUP_LAST   3'h7
`define EFS_WLEN_LO      3'h6
`define EFS_WLEN_HI      3'h7
// endpoint index of the shared ep0 stall bit
`define EFS_EP0_IDX      4'h0
// ep0 control/status field positions
`define EFS_STALL_BIT    0
`define EFS_HANDSHAKE_NAK_HOLD_BIT    1
`define EFS_AUTO_BIT     2
// reset values
`define EFS_PTR_RST      16'h0000
`define EFS_CS_RST       8'h00
`endif

// [rtl/efs_pkg.sv]
package efs_pkg;
  // token identifiers as seen by the serial engine
  typedef enum logic [1:0] {
    PID_OUT   = 2'h0,
    PID_IN    = 2'h1,
    PID_SETUP = 2'h2
  } efs_pid_e;

  // answer to a token; HS_DATA sends the auto descriptor packet
  typedef enum logic [1:0] {
    HS_ACK   = 2'h0,
    HS_NAK   = 2'h1,
    HS_STALL = 2'h2,
    HS_DATA  = 2'h3
  } efs_hs_e;

  // decoded token: pid, direction (1 = in) and endpoint number
  typedef struct packed {
    efs_pid_e   pid;
    logic       dir_in;
    logic [2:0] num;
  } efs_tok_s;

  // descriptor sequencer, gray along idle-len-fetch-data-status
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LEN   = 3'h1,
    ST_FETCH = 3'h3,
    ST_DATA  = 3'h2,
    ST_STAT  = 3'h6
  } efs_state_e;
endpackage : efs_pkg

// [dv/efs_host_model.sv]
`timescale 1ns/100ps
module efs_host_model import efs_pkg::*; (
  input  wire logic clk,       // core clock
  output logic      tok_valid, // token strobe
  output efs_tok_s  tok,       // decoded token
  output logic      sb_valid,  // setup byte strobe
  output logic [7:0] sb,       // setup byte
  output logic      in_ack     // host acked ep0 in packet
);
  // lines idle low; stale values are inverted so nothing reads as held
  initial begin
    tok_valid = 1'b0;
    tok       = '0;
    sb_valid  = 1'b0;
    sb        = 8'h00;
    in_ack    = 1'b0;
  end

  // one token, one cycle; callers start just after a rising edge
  task automatic send_tok(efs_pid_e p, logic d, logic [2:0] n);
    tok_valid = 1'b1;
    tok = '{pid: p, dir_in: d, num: n};
    @(posedge clk);
    #1;
    tok_valid = 1'b0;
    tok = ~tok;
    // idle edge so a following token never re-raises the strobe at once
    @(posedge clk);
    #1;
  endtask : send_tok

  // eight setup bytes back to back, byte 0 first
  task automatic send_setup(logic [63:0] b);
    sb_valid = 1'b1;
    for (int i = 0; i < 8; i++) begin
      sb = b[8*i +: 8];
      @(posedge clk);
      #1;
    end
    sb_valid = 1'b0;
    sb = ~sb;
  endtask : send_setup

  task automatic ack();
    in_ack = 1'b1;
    @(posedge clk);
    #1;
    in_ack = 1'b0;
  endtask : ack
endmodule : efs_host_model

// [dv/ep0_feature_stall_descriptor_test.sv]
`timescale 1ns/100ps
module ep0_feature_stall_descriptor_test;
  import efs_pkg::*;
  logic clk, sys_rst, tok_valid, sbv, in_ack, xfer_done, fw_stall_set;
  logic fw_stall_clr, fw_toggle_rst, fw_nak_release, fw_ptr_hi_wr;
  logic fw_ptr_lo_wr, fw_rwu_set, fw_rwu_clr, rd_n, hs_valid;
  logic desc_rd_en, setup_data_avail_irq, ep0_in_done_irq;
  logic remote_wakeup_enable;
  logic [15:0] ep_iso, ep_ready, in_pkt_addr, desc_rd_addr, ep_stall;
  logic [15:0] data_pid_odd, ptr;
  logic [7:0]  sb, fw_ptr_byte, desc_rd_data, desc_len, cs, setup_rd_data;
  logic [3:0]  xfer_ep, fw_ep, ep;
  logic [2:0]  setup_rd_idx;
  logic [6:0]  in_pkt_len;
  logic [24:0] exp_q[$];
  logic [24:0] e;
  efs_tok_s    tok;
  efs_hs_e     hs_code;
  int          failures, tests_run, rem, n;
  logic [15:0] wl[3] = '{16'h00ff, 16'h0010, 16'h0080};
  logic [7:0]  dl[3] = '{8'h5b, 8'h5b, 8'h40};

  efs_host_model efs_host_model_i (.clk(clk), .tok_valid(tok_valid),
    .tok(tok), .sb_valid(sbv), .sb(sb), .in_ack(in_ack));

  efs_ep0_core efs_ep0_core_i (.clk(clk), .sys_rst(sys_rst),
    .tok_valid(tok_valid), .tok(tok), .ep_iso(ep_iso),
    .ep_ready(ep_ready), .xfer_done(xfer_done), .xfer_ep(xfer_ep),
    .setup_byte_valid(sbv), .setup_byte(sb), .in_ack(in_ack),
    .fw_stall_set(fw_stall_set), .fw_stall_clr(fw_stall_clr),
    .fw_ep(fw_ep), .fw_toggle_rst(fw_toggle_rst),
    .fw_nak_release(fw_nak_release), .fw_ptr_hi_wr(fw_ptr_hi_wr),
    .fw_ptr_lo_wr(fw_ptr_lo_wr), .fw_ptr_byte(fw_ptr_byte),
    .fw_rwu_set(fw_rwu_set), .fw_rwu_clr(fw_rwu_clr),
    .setup_rd_idx(setup_rd_idx), .desc_rd_data(desc_rd_data),
    .hs_valid(hs_valid), .hs_code(hs_code), .in_pkt_addr(in_pkt_addr),
    .in_pkt_len(in_pkt_len), .desc_rd_en(desc_rd_en),
    .desc_rd_addr(desc_rd_addr),
    .setup_data_avail_irq(setup_data_avail_irq),
    .ep0_in_done_irq(ep0_in_done_irq), .ep_stall(ep_stall),
    .data_pid_odd(data_pid_odd), .ep0_control_status(cs),
    .setup_rd_data(setup_rd_data),
    .remote_wakeup_enable(remote_wakeup_enable));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // descriptor ram, one cycle latency; idle data inverted to expose misuse
  always @(negedge clk) rd_n <= desc_rd_en;
  always @(posedge clk) #1 desc_rd_data = rd_n ? desc_len : ~desc_len;

  task automatic chk(string nm, logic [24:0] x, logic [24:0] g);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // answers checked mid cycle against the oldest queued expectation
  always @(negedge clk) begin
    if (sys_rst === 1'b0 && hs_valid !== 1'b0) begin
      if (exp_q.size() == 0) chk("hs_unexpected", 25'h0, 25'h1);
      else begin
        e = exp_q.pop_front();
        chk("handshake", e, {hs_code, (e[24:23] == 2'h3) ?
            {in_pkt_len, in_pkt_addr} : e[22:0]});
      end
    end
  end

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
  endtask : pulse

  task automatic tk(efs_pid_e p, logic [3:0] q, efs_hs_e c,
                    logic [22:0] la);
    if (ep_iso[q] !== 1'b1) exp_q.push_back({c, la});
    efs_host_model_i.send_tok(p, q[3], q[2:0]);
  endtask : tk

  task automatic wrap_up();
    chk("queue_empty", 25'h0, 25'(exp_q.size()));
    $display("comparisons %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #(100 * 5000);
    failures++;
    wrap_up();
  end

  initial begin
    {sys_rst, xfer_done, fw_stall_set, fw_stall_clr, fw_toggle_rst} = 5'h10;
    {fw_nak_release, fw_ptr_hi_wr, fw_ptr_lo_wr, fw_rwu_set} = 4'h0;
    {fw_rwu_clr, ep_iso, ep_ready, xfer_ep, fw_ep} = '0;
    {fw_ptr_byte, setup_rd_idx, desc_len, desc_rd_data} = '0;
    failures = 0;
    tests_run = 0;
    void'($urandom(78744));
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk("rst_stall", 25'h0, ep_stall);
    chk("rst_status", 25'h0, cs);
    chk("rst_toggle", 25'h0, data_pid_odd);
    chk("rst_hs", 25'h1, hs_code);
    // ep0 stall lasts only until the next setup
    fw_ep = 4'h8;
    pulse(fw_stall_set);
    chk("ep0_stall", 25'h1, ep_stall);
    tk(PID_IN, 4'h8, HS_STALL, 23'h0);
    chk("cs_stall", 25'h1, cs);
    tk(PID_OUT, 4'h0, HS_STALL, 23'h0);
    tk(PID_SETUP, 4'h0, HS_ACK, 23'h0);
    efs_host_model_i.send_setup(64'h0002_0000_0000_0081);
    chk("setup_irq", 25'h1, setup_data_avail_irq);
    chk("ep0_autoclear", 25'h0, ep_stall);
    chk("hold_set", 25'h2, cs);
    chk("ep0_toggles", 25'h101, data_pid_odd);
    for (int i = 0; i < 8; i++) begin
      setup_rd_idx = 3'(i);
      step();
      chk("setup_ram", 25'(8'(64'h0002_0000_0000_0081 >> (8 * i))),
          setup_rd_data);
    end
    ep_ready = 16'hffff;
    tk(PID_IN, 4'h8, HS_NAK, 23'h0);
    pulse(fw_nak_release);
    step();
    chk("hold_release", 25'h0, cs);
    tk(PID_IN, 4'h8, HS_ACK, 23'h0);
    // bulk endpoints: toggle flip, stall, toggle reset, iso silence, then firmware clear
    for (int k = 0; k < 6; k++) begin
      ep = {1'($urandom), 3'(1 + $urandom % 7)};
      ep_ready = 16'($urandom);
      fw_ep = ep;
      xfer_ep = ep;
      pulse(xfer_done);
      chk("toggle_flip", 25'h101 | (25'h1 << ep), data_pid_odd);
      pulse(fw_stall_set);
      pulse(fw_toggle_rst);
      chk("toggle_rst", 25'h101, data_pid_odd);
      chk("stall_bit", 25'h1 << ep, ep_stall);
      tk(ep[3] ? PID_IN : PID_OUT, ep, HS_STALL, 23'h0);
      ep_iso[ep] = 1'b1;
      tk(PID_IN, ep, HS_STALL, 23'h0);
      ep_iso[ep] = 1'b0;
      pulse(fw_stall_clr);
      chk("stall_clr", 25'h0, ep_stall);
      tk(PID_OUT, ep, ep_ready[ep] ? HS_ACK : HS_NAK, 23'h0);
    end
    ep_ready = 16'hffff;
    // remote wakeup enable, set wins over a simultaneous clear
    pulse(fw_rwu_set);
    chk("rwu_set", 25'h1, remote_wakeup_enable);
    step();
    fw_rwu_clr = 1'b1;
    pulse(fw_rwu_set);
    fw_rwu_clr = 1'b0;
    chk("rwu_both", 25'h1, remote_wakeup_enable);
    pulse(fw_rwu_clr);
    chk("rwu_clr", 25'h0, remote_wakeup_enable);
    // automatic descriptor stage: long, short and exact multiple of 64
    for (int k = 0; k < 3; k++) begin
      desc_len = dl[k];
      ptr = 16'($urandom);
      tk(PID_SETUP, 4'h0, HS_ACK, 23'h0);
      efs_host_model_i.send_setup({wl[k], 48'h0000_0100_0680});
      step();
      pulse(fw_nak_release);
      fw_ptr_byte = ptr[15:8];
      pulse(fw_ptr_hi_wr);
      fw_ptr_byte = ptr[7:0];
      pulse(fw_ptr_lo_wr);
      chk("desc_addr", 25'(ptr), desc_rd_addr);
      repeat (3) step();
      rem = (wl[k] < 16'(dl[k])) ? int'(wl[k]) : int'(dl[k]);
      do begin
        n = (rem > 64) ? 64 : rem;
        tk(PID_IN, 4'h8, HS_DATA, {7'(n), ptr});
        if (k == 0) tk(PID_IN, 4'h8, HS_DATA, {7'(n), ptr});
        step();
        efs_host_model_i.ack();
        chk("in_done_irq", 25'h1, ep0_in_done_irq);
        ptr += 16'(n);
        rem -= n;
      end while (n == 64);
      tk(PID_OUT, 4'h0, HS_ACK, 23'h0);
    end
    tk(PID_IN, 4'h8, HS_ACK, 23'h0);
    repeat (3) step();
    wrap_up();
  end
endmodule : ep0_feature_stall_descriptor_test
